// ==== rtl/cwd_pkg.sv ====
// What this block does
// - Extended-set bit 6 set enables extension and indexed addressing; clear is legacy.
// - Low-voltage programming bit 2 changes only in high-voltage programming mode.
// - Stack-error bit 0 set makes stack full or underflow cause a reset.
// - Unimplemented configuration bits, including protect byte bits 7-4, read zero.
// - Four protect bits guard one block each; one unprotected, zero protected.
// - Protect bits are clear-only; writes may clear but never set them.
// - Protect bits for blocks 2 and 3 exist only on larger memory variants.
// - Unprogrammed values: 0,0,1,0,0101; debug 1, ext 0, lvp 1, stack 1, protect all 1.
package cwd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] CWD_ADDR_OSC = 2'h0;
  localparam logic [1:0] CWD_ADDR_DBG = 2'h1;
  localparam logic [1:0] CWD_ADDR_PROT = 2'h2;
  localparam logic [1:0] CWD_ADDR_STAT = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CWD_OSC_SWITCH_BIT = 7;
  localparam int CWD_OSC_MONITOR_BIT = 6;
  localparam int CWD_OSC_PRIMARY_BIT = 5;
  localparam int CWD_OSC_PLL_BIT = 4;
  localparam int CWD_DBG_DEBUG_BIT = 7;
  localparam int CWD_DBG_EXT_BIT = 6;
  localparam int CWD_DBG_LVP_BIT = 2;
  localparam int CWD_DBG_STACK_BIT = 0;

  // ----------------------------------------------------------------
  // Unprogrammed values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CWD_OSC_RESET = 8'h25;
  localparam logic [7:0] CWD_DBG_RESET = 8'h85;
  localparam logic [7:0] CWD_PROT_RESET = 8'h0F;
  localparam logic [7:0] CWD_OSC_MASK = 8'hFF;
  localparam logic [7:0] CWD_DBG_MASK = 8'hC5;
  localparam logic [7:0] CWD_PROT_MASK_SMALL = 8'h03;
  localparam logic [7:0] CWD_PROT_MASK_LARGE = 8'h0F;

  // ----------------------------------------------------------------
  // Oscillator source classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CWD_SRC_LP, CWD_SRC_XT, CWD_SRC_HS, CWD_SRC_EC, CWD_SRC_RC, CWD_SRC_INT
  } cwd_src_t;

endpackage

// ==== rtl/cwd_osc_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module cwd_osc_decode
  import cwd_pkg::*;
(
  // Select field.
  input wire logic [3:0] sel,
  // Decoded source.
  output cwd_src_t src,
  output logic clkout_en,
  output logic crystal
);

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  // Even external clock codes and the RC pair with clock out share one table.
  always_comb begin
    clkout_en = 1'b0;
    unique case (sel)
      4'h0: src = CWD_SRC_LP;
      4'h1: src = CWD_SRC_XT;
      4'h2, 4'h3: src = CWD_SRC_HS;
      4'h4, 4'h5, 4'hA, 4'hB, 4'hC, 4'hD: begin
        src = CWD_SRC_EC;
        clkout_en = (sel == 4'h4) || (sel == 4'hA) || (sel == 4'hC);
      end
      4'h6, 4'h7, 4'hE, 4'hF: begin
        src = CWD_SRC_RC;
        clkout_en = (sel == 4'h6) || (sel == 4'hE);
      end
      4'h8, 4'h9: begin
        src = CWD_SRC_INT;
        clkout_en = (sel == 4'h9);
      end
    endcase
  end

  assign crystal = (src == CWD_SRC_LP) || (src == CWD_SRC_XT) || (src == CWD_SRC_HS);

endmodule
`default_nettype wire

// ==== rtl/cwd_config_word.sv ====
`timescale 1ns/100ps
`default_nettype none
module cwd_config_word
  import cwd_pkg::*;
#(
  parameter bit LARGE_MEMORY = 1'b1
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Programmer register port.
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Mode pin and core events.
  input wire logic HV_PROG_MODE,
  input wire logic PLL_SOFT_ENABLE,
  input wire logic STACK_FAULT,
  // Decoded configuration.
  output logic OSC_SWITCHOVER_EN,
  output logic CLOCK_MONITOR_EN,
  output logic PRIMARY_CLOCK_ALWAYS_ON,
  output logic PLL_ACTIVE,
  output logic [2:0] OSC_SOURCE,
  output logic OSC_CLKOUT_EN,
  output logic DEBUGGER_EN,
  output logic EXTENDED_SET_EN,
  output logic LOW_VOLTAGE_PROG_EN,
  output logic STACK_RESET,
  output logic [3:0] PROTECT_BLOCK,
  output logic SWITCHOVER_ADVISED
);

  // Blocks 2 and 3 only exist on large variants.
  localparam logic [7:0] PROT_MASK = LARGE_MEMORY ? CWD_PROT_MASK_LARGE :
                                                    CWD_PROT_MASK_SMALL;

  logic [7:0] osc_r;
  logic [7:0] dbg_r;
  logic [7:0] prot_r;
  logic hv_meta_r;
  logic hv_r;
  logic [1:0] fault_sync_r;
  logic [7:0] rd_nxt;
  logic [7:0] dbg_nxt;
  cwd_src_t src;
  logic clkout_en;
  logic crystal;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The mode pin comes from the programmer pins, so it is synchronised.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hv_meta_r <= 1'b0;
      hv_r <= 1'b0;
    end else begin
      hv_meta_r <= HV_PROG_MODE;
      hv_r <= hv_meta_r;
    end
  end

  // Stack faults come from the core clock domain but are staged to the output flop.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fault_sync_r <= 2'h0;
    end else begin
      fault_sync_r <= {fault_sync_r[0], STACK_FAULT};
    end
  end

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  // Oscillator byte: a plain programmable byte.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      osc_r <= CWD_OSC_RESET;
    end else if (WR && ADDR == CWD_ADDR_OSC) begin
      osc_r <= WDATA & CWD_OSC_MASK;
    end
  end

  // The low-voltage bit keeps its value unless the part is in high-voltage mode.
  always_comb begin
    dbg_nxt = WDATA & CWD_DBG_MASK;
    if (!hv_r) begin
      dbg_nxt[CWD_DBG_LVP_BIT] = dbg_r[CWD_DBG_LVP_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dbg_r <= CWD_DBG_RESET;
    end else if (WR && ADDR == CWD_ADDR_DBG) begin
      dbg_r <= dbg_nxt;
    end
  end

  // Protect bits only ever clear; a write of one leaves them as they are.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prot_r <= CWD_PROT_RESET & PROT_MASK;
    end else if (WR && ADDR == CWD_ADDR_PROT) begin
      prot_r <= prot_r & WDATA & PROT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Status word exposes the synchronised mode pin and crystal advisory.
  always_comb begin
    unique case (ADDR)
      CWD_ADDR_OSC: rd_nxt = osc_r;
      CWD_ADDR_DBG: rd_nxt = dbg_r;
      CWD_ADDR_PROT: rd_nxt = prot_r;
      CWD_ADDR_STAT: rd_nxt = {5'h00, crystal, SWITCHOVER_ADVISED, hv_r};
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_nxt : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cwd_osc_decode u_dec (
    .sel(osc_r[3:0]),
    .src(src),
    .clkout_en(clkout_en),
    .crystal(crystal)
  );

  // Registered outputs; they lag the storage by one cycle, harmless for static bytes.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OSC_SWITCHOVER_EN <= 1'b0;
      CLOCK_MONITOR_EN <= 1'b0;
      PRIMARY_CLOCK_ALWAYS_ON <= 1'b1;
      PLL_ACTIVE <= 1'b0;
      OSC_SOURCE <= 3'h0;
      OSC_CLKOUT_EN <= 1'b0;
      DEBUGGER_EN <= 1'b0;
      EXTENDED_SET_EN <= 1'b0;
      LOW_VOLTAGE_PROG_EN <= 1'b1;
      STACK_RESET <= 1'b0;
      PROTECT_BLOCK <= 4'h0;
      SWITCHOVER_ADVISED <= 1'b0;
    end else begin
      OSC_SWITCHOVER_EN <= osc_r[CWD_OSC_SWITCH_BIT];
      CLOCK_MONITOR_EN <= osc_r[CWD_OSC_MONITOR_BIT];
      PRIMARY_CLOCK_ALWAYS_ON <= osc_r[CWD_OSC_PRIMARY_BIT];
      PLL_ACTIVE <= osc_r[CWD_OSC_PLL_BIT] | PLL_SOFT_ENABLE;
      OSC_SOURCE <= 3'(src);
      OSC_CLKOUT_EN <= clkout_en;
      DEBUGGER_EN <= ~dbg_r[CWD_DBG_DEBUG_BIT];
      EXTENDED_SET_EN <= dbg_r[CWD_DBG_EXT_BIT];
      LOW_VOLTAGE_PROG_EN <= dbg_r[CWD_DBG_LVP_BIT];
      STACK_RESET <= fault_sync_r[1] & dbg_r[CWD_DBG_STACK_BIT];
      PROTECT_BLOCK <= ~prot_r[3:0] & PROT_MASK[3:0];
      SWITCHOVER_ADVISED <= crystal & osc_r[CWD_OSC_MONITOR_BIT] &
                            ~osc_r[CWD_OSC_SWITCH_BIT];
    end
  end

endmodule
`default_nettype wire

// ==== verif/cwd_config_word_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module cwd_config_word_asserts
  import cwd_pkg::*;
#(
  parameter bit LARGE_MEMORY = 1'b1
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Register port.
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Mode and events.
  input wire logic HV_PROG_MODE,
  input wire logic PLL_SOFT_ENABLE,
  input wire logic STACK_FAULT,
  // Decoded outputs.
  input wire logic OSC_SWITCHOVER_EN,
  input wire logic CLOCK_MONITOR_EN,
  input wire logic PRIMARY_CLOCK_ALWAYS_ON,
  input wire logic PLL_ACTIVE,
  input wire logic EXTENDED_SET_EN,
  input wire logic LOW_VOLTAGE_PROG_EN,
  input wire logic STACK_RESET,
  input wire logic [3:0] PROTECT_BLOCK
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // ----------------------------------------------------------------
  // Write steps
  // ----------------------------------------------------------------
  sequence osc_wr;
    WR && ADDR == CWD_ADDR_OSC;
  endsequence
  sequence dbg_wr;
    WR && ADDR == CWD_ADDR_DBG;
  endsequence
  AST_SWITCH: assert property (osc_wr |=> ##1 OSC_SWITCHOVER_EN == $past(WDATA[7], 2))
    else $error("switchover output does not follow written bit");
  AST_MONITOR: assert property (osc_wr |=> ##1 CLOCK_MONITOR_EN == $past(WDATA[6], 2))
    else $error("monitor output does not follow written bit");
  AST_PRIMARY: assert property (osc_wr |=> ##1 PRIMARY_CLOCK_ALWAYS_ON == $past(WDATA[5], 2))
    else $error("primary clock output does not follow written bit");
  AST_EXT: assert property (dbg_wr |=> ##1 EXTENDED_SET_EN == $past(WDATA[6], 2))
    else $error("extended set output does not follow written bit");
  // Synchronised mode lags the pin, so three low cycles make the write a refused one.
  AST_LVP_HOLD: assert property (!HV_PROG_MODE [*3] ##0 dbg_wr |=> ##1 $stable(LOW_VOLTAGE_PROG_EN))
    else $error("low voltage enable changed outside programming mode");
  AST_STACK: assert property (STACK_RESET |-> $past(STACK_FAULT, 3))
    else $error("stack reset without a fault three cycles earlier");
  AST_UNIMPL: assert property (RD && ADDR == CWD_ADDR_PROT |=>
    (RDATA & ~(LARGE_MEMORY ? CWD_PROT_MASK_LARGE : CWD_PROT_MASK_SMALL)) == 8'h00)
    else $error("unimplemented protect bits read nonzero");
  AST_PROT_CLEAR: assert property (($past(PROTECT_BLOCK) & ~PROTECT_BLOCK) == 4'h0)
    else $error("protected block became unprotected");
  AST_PLL: assert property (PLL_SOFT_ENABLE |=> PLL_ACTIVE)
    else $error("software enable did not activate the multiplier");
endmodule
bind cwd_config_word cwd_config_word_asserts #(.LARGE_MEMORY(LARGE_MEMORY)) cwd_config_word_asserts_inst (
  .CORE_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .HV_PROG_MODE, .PLL_SOFT_ENABLE,
  .STACK_FAULT, .OSC_SWITCHOVER_EN, .CLOCK_MONITOR_EN, .PRIMARY_CLOCK_ALWAYS_ON, .PLL_ACTIVE,
  .EXTENDED_SET_EN, .LOW_VOLTAGE_PROG_EN, .STACK_RESET, .PROTECT_BLOCK);
`default_nettype wire

// ==== verif/cwd_prog_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cwd_prog_model (
  // High-voltage programming entry.
  output logic HV_PROG_MODE
);
  initial HV_PROG_MODE = 1'b0;
  // The low-voltage enable is only rewritten with high voltage applied.
  task automatic set_hv(input logic v);
    HV_PROG_MODE <= v;
  endtask
  // A crystal source with the monitor on also gets switchover, to avoid false failures.
  function automatic logic [7:0] osc_byte(input logic [3:0] sel, input logic mon);
    return {mon & (sel < 4'h4), mon, 2'b00, sel};
  endfunction
  // The debugger bit stays high so the debug pins remain plain I/O.
  function automatic logic [7:0] dbg_byte(input logic [6:0] low);
    return {1'b1, low};
  endfunction
endmodule
`default_nettype wire

// ==== verif/tb_cwd_config_word.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_cwd_config_word import cwd_pkg::*;;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pll_sw = 1'b0, fault = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic sw, mon, pri, pll, clko, dbg, ext, low_voltage_prog_en, stk, adv;
  logic [2:0] src;
  logic [3:0] prot;
  wire hv;
  int bad_count = 0, checks_done = 0;
  // ----------------------------------------------------------------
  // Design and programmer
  // ----------------------------------------------------------------
  cwd_prog_model cwd_prog_model_inst (.HV_PROG_MODE(hv));
  cwd_config_word cwd_config_word_inst (.CORE_CLK(clk), .RESETN(rstn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .HV_PROG_MODE(hv),
    .PLL_SOFT_ENABLE(pll_sw), .STACK_FAULT(fault), .OSC_SWITCHOVER_EN(sw),
    .CLOCK_MONITOR_EN(mon), .PRIMARY_CLOCK_ALWAYS_ON(pri), .PLL_ACTIVE(pll),
    .OSC_SOURCE(src), .OSC_CLKOUT_EN(clko), .DEBUGGER_EN(dbg), .EXTENDED_SET_EN(ext),
    .LOW_VOLTAGE_PROG_EN(low_voltage_prog_en), .STACK_RESET(stk), .PROTECT_BLOCK(prot),
    .SWITCHOVER_ADVISED(adv));
  // The 125 MHz core clock.
  always #4 clk = ~clk;
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Outputs trail the register by one more edge.
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #200000;
    bad_count++;
    results();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(CWD_ADDR_OSC, 8'h25);
    rd_reg(CWD_ADDR_DBG, 8'h85);
    rd_reg(CWD_ADDR_PROT, 8'h0F);
    chk({1'b0, pri, low_voltage_prog_en, stk, prot}, 8'h60);
    wr_reg(CWD_ADDR_OSC, cwd_prog_model_inst.osc_byte(4'h2, 1'b1));
    settle();
    chk({2'b00, sw, mon, pri, src}, {2'b00, 3'b110, 3'h2});
    chk({7'h00, adv}, 8'h00);
    // A crystal with the monitor on but no switchover must raise the advisory.
    wr_reg(CWD_ADDR_OSC, 8'h42);
    settle();
    chk({7'h00, adv}, 8'h01);
    rd_reg(CWD_ADDR_STAT, 8'h06);
    // Every select code, with the multiplier left to software.
    for (int i = 0; i < 16; i++) begin
      wr_reg(CWD_ADDR_OSC, {4'h0, i[3:0]});
      settle();
      chk(src, i < 2 ? i : i < 4 ? 2 : i < 6 ? 3 : i < 8 ? 4 : i < 10 ? 5 : i < 14 ? 3 : 4);
      chk({pll, clko}, {1'b0, i inside {4, 6, 9, 10, 12, 14}});
    end
    wr_reg(CWD_ADDR_OSC, 8'h15);
    settle();
    chk(pll, 8'h01);
    pll_sw <= 1'b1;
    wr_reg(CWD_ADDR_OSC, 8'h05);
    settle();
    chk(pll, 8'h01);
    wr_reg(CWD_ADDR_DBG, cwd_prog_model_inst.dbg_byte(7'h40));
    settle();
    chk({dbg, ext, low_voltage_prog_en}, 8'h03);
    rd_reg(CWD_ADDR_DBG, 8'hC4);
    cwd_prog_model_inst.set_hv(1'b1);
    // The mode pin needs two edges through its synchroniser before a write sees it.
    repeat (2) @(posedge clk);
    wr_reg(CWD_ADDR_DBG, 8'h01);
    settle();
    chk({ext, low_voltage_prog_en}, 8'h00);
    fault <= 1'b1;
    settle();
    chk(stk, 8'h01);
    fault <= 1'b0;
    wr_reg(CWD_ADDR_DBG, 8'h80);
    fault <= 1'b1;
    settle();
    chk(stk, 8'h00);
    wr_reg(CWD_ADDR_PROT, 8'hFA);
    wr_reg(CWD_ADDR_PROT, 8'hFF);
    settle();
    chk(prot, 8'h05);
    rd_reg(CWD_ADDR_PROT, 8'h0A);
    results();
  end
endmodule
`default_nettype wire
